// ===== rtl/ncfg_pkg.sv
// Constants, types and state codes for the serial-access configuration selector.
// Assumes one 20 MHz system clock; every pin is asynchronous to it.
// What this block does
// RQ1: Select low: outputs follow register selector bits.
// RQ2: Select high: outputs follow external inputs.
// RQ3: Held output via latch, transparent while select low.
// RQ4: Held value is that shown when select rose.
// RQ5: Writes during select high leave held output.
// RQ6: Force low with select low zeroes outputs.
// RQ7: Write lock low allows serial register writes.
// RQ8: Write lock high keeps register unchanged.
// RQ9: Register starts all zero before any write.
// RQ10: Seven-bit address plus direction; answer own address.
// RQ11: Exactly eight data bits follow address acknowledge.
// RQ12: Store byte only on write with lock low.
// RQ13: Read drives register contents as eight bits.
// RQ14: Byte: three zeros, held bit, four selector bits.
// RQ15: Nonzero top three bits abort the write.
// RQ16: Block writes when either supply is low.
// RQ17: Update register only after all eight bits.
// RQ18: Ignore other addresses, data line stays released.
package ncfg_pkg;

	// Stored register width, value after reset and field positions.
	localparam int NV_WIDTH = 5;
	localparam logic [4:0] NV_RESET = 5'h00;
	localparam int HELD_BIT = 4;
	localparam int SEL_MSB = 3;
	localparam int PAD_MSB = 7;
	localparam int PAD_LSB = 5;
	localparam logic [2:0] PAD_ZERO = 3'h0;

	// Serial framing: bits per byte and counter reset value.
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_READ_BIT = 4'h7;
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam logic [7:0] SHIFT_RESET = 8'h00;

	// Slave address default; the value is arbitrary.
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

	// Serial slave states, one-hot.
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_AACK = 8'h04,
		ST_WDATA = 8'h08,
		ST_WACK = 8'h10,
		ST_RDATA = 8'h20,
		ST_RACK = 8'h40,
		ST_SKIP = 8'h80
	} ncfg_state_t;

	// All pin inputs, carried together through the synchroniser.
	typedef struct packed {
		logic scl;
		logic sda;
		logic force_low_n;
		logic write_lock;
		logic path_select;
		logic bus_supply_ok;
		logic core_supply_ok;
		logic [3:0] ext_inputs;
	} ncfg_pins_t;

	localparam ncfg_pins_t PINS_RESET = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'hf};

endpackage : ncfg_pkg

// ===== rtl/ncfg_top.sv
// Configuration selector with a serial two-wire slave and a five-bit stored register.
// Assumes all pins are asynchronous to clk_i and that the data line is open drain with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module ncfg_top
	import ncfg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic force_low_n_i,
	input wire logic write_lock_i,
	input wire logic path_select_i,
	input wire logic bus_supply_ok_i,
	input wire logic core_supply_ok_i,
	input wire logic [3:0] ext_inputs_i,
	output logic [3:0] selector_outputs_o,
	output logic held_output_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation and bus event detection.

	ncfg_pins_t pins_raw;
	ncfg_pins_t pins_meta_reg;
	ncfg_pins_t pins_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign pins_raw = '{scl_i, sda_i, force_low_n_i, write_lock_i, path_select_i,
		bus_supply_ok_i, core_supply_ok_i, ext_inputs_i};

	// Two flops on every pin; only the second one is read by logic.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pins_meta_reg <= PINS_RESET;
			pins_reg <= PINS_RESET;
		end else begin
			pins_meta_reg <= pins_raw;
			pins_reg <= pins_meta_reg;
		end
	end

	// Previous sampled levels of the bus lines, for edge finding.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= pins_reg.scl;
			sda_prev_reg <= pins_reg.sda;
		end
	end

	// Clock edges, and start and stop as data edges while the clock is high.
	assign scl_rise = pins_reg.scl && !scl_prev_reg;
	assign scl_fall = !pins_reg.scl && scl_prev_reg;
	assign start_det = pins_reg.scl && scl_prev_reg && sda_prev_reg && !pins_reg.sda;
	assign stop_det = pins_reg.scl && scl_prev_reg && !sda_prev_reg && pins_reg.sda;

	////////////////////////////////////////////////////////////////////////////////
	// Serial slave state machine.

	ncfg_state_t state_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg;
	logic rw_reg;
	logic accept_reg;
	logic [4:0] nv_reg;
	logic wr_done;
	logic wr_ok;

	// A data byte is complete on the clock fall after its eighth bit.
	assign wr_done = (state_reg == ST_WDATA) && scl_fall && (cnt_reg == BYTE_BITS) && !start_det && !stop_det;
	// A write is kept only when unlocked, padded with zeros and fully powered.
	assign wr_ok = !pins_reg.write_lock && (shift_reg[PAD_MSB:PAD_LSB] == PAD_ZERO)
		&& pins_reg.bus_supply_ok && pins_reg.core_supply_ok; // see RQ7 see RQ15 see RQ16

	// Bit counting, shifting and the transaction sequence.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= CNT_RESET;
			shift_reg <= SHIFT_RESET;
			rw_reg <= 1'b0;
		end else if (start_det) begin
			state_reg <= ST_ADDR;
			cnt_reg <= CNT_RESET;
		end else if (stop_det) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					cnt_reg <= CNT_RESET;
				end
				ST_ADDR: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], pins_reg.sda};
						cnt_reg <= cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == BYTE_BITS) begin
						cnt_reg <= CNT_RESET;
						if (shift_reg[7:1] == DEV_ADDR) begin // see RQ10
							state_reg <= ST_AACK;
							rw_reg <= shift_reg[0];
						end else begin
							state_reg <= ST_SKIP; // see RQ18
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							state_reg <= ST_RDATA;
							shift_reg <= {PAD_ZERO, nv_reg}; // see RQ13 see RQ14
						end else begin
							state_reg <= ST_WDATA;
						end
					end
				end
				ST_WDATA: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], pins_reg.sda};
						cnt_reg <= cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == BYTE_BITS) begin
						state_reg <= ST_WACK; // see RQ11
					end
				end
				ST_WACK: begin
					if (scl_fall) begin
						state_reg <= ST_SKIP;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						shift_reg <= {shift_reg[6:0], 1'b1};
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == LAST_READ_BIT) begin
							state_reg <= ST_RACK; // see RQ11
						end
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						state_reg <= ST_SKIP;
					end
				end
				ST_SKIP: begin
					cnt_reg <= CNT_RESET;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Remember whether the last data byte was taken, for its acknowledge.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			accept_reg <= 1'b0;
		end else if (wr_done) begin
			accept_reg <= wr_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stored register.

	// Loaded only when a whole valid byte has arrived; otherwise left alone.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			nv_reg <= NV_RESET; // see RQ9
		end else if (wr_done && wr_ok && !rw_reg) begin
			nv_reg <= shift_reg[NV_WIDTH-1:0]; // see RQ12 see RQ17 see RQ8
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data line driver.

	// Pull low for address and accepted data acknowledges and for zero read bits.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			case (state_reg)
				ST_AACK: sda_oe_o <= 1'b1;
				ST_WACK: sda_oe_o <= accept_reg;
				ST_RDATA: sda_oe_o <= !shift_reg[7]; // see RQ13
				default: sda_oe_o <= 1'b0; // see RQ18
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Selector and held output.

	// Selector follows external inputs, or the register unless forced low.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			selector_outputs_o <= 4'h0;
		end else if (pins_reg.path_select) begin
			selector_outputs_o <= pins_reg.ext_inputs; // see RQ2
		end else if (!pins_reg.force_low_n) begin
			selector_outputs_o <= 4'h0; // see RQ6
		end else begin
			selector_outputs_o <= nv_reg[SEL_MSB:0]; // see RQ1
		end
	end

	// Held output is transparent while select is low and freezes when it rises.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			held_output_o <= 1'b0;
		end else if (!pins_reg.path_select) begin // see RQ4 see RQ5
			held_output_o <= pins_reg.force_low_n && nv_reg[HELD_BIT]; // see RQ3 see RQ6
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// With select low and no force, the selector shows the register one cycle later.
	a_sel_from_reg: assert property (!pins_reg.path_select && pins_reg.force_low_n // see RQ1
		|=> selector_outputs_o == $past(nv_reg[SEL_MSB:0]))
		else $error("selector does not follow register");
	// With select high, the selector shows the synchronised external inputs.
	a_sel_from_ext: assert property (pins_reg.path_select // see RQ2
		|=> selector_outputs_o == $past(pins_reg.ext_inputs))
		else $error("selector does not follow external inputs");
	// While select is low, the held flop tracks the register bit, gated by the force pin.
	a_held_transp: assert property (!pins_reg.path_select // see RQ3
		|=> held_output_o == $past(pins_reg.force_low_n && nv_reg[HELD_BIT]))
		else $error("held output not transparent");
	// Checked after two select-high samples, though the flop already holds from the edge at which the first is seen.
	a_held_frozen: assert property (pins_reg.path_select ##1 pins_reg.path_select // see RQ4 see RQ5
		|=> $stable(held_output_o))
		else $error("held output moved while latched");
	// Force with select low clears both the selector and the held output.
	a_force_zero: assert property (!pins_reg.path_select && !pins_reg.force_low_n // see RQ6
		|=> selector_outputs_o == 4'h0 && !held_output_o)
		else $error("force low not applied");
	// While the lock is high, the register must not change.
	a_lock_keeps: assert property (pins_reg.write_lock |=> $stable(nv_reg)) // see RQ8
		else $error("register changed while locked");
	// A byte with a nonzero pad is dropped and answered with a released line.
	a_pad_abort: assert property (wr_done && shift_reg[PAD_MSB:PAD_LSB] != PAD_ZERO // see RQ15
		|=> $stable(nv_reg) ##1 sda_oe_o == 1'b0)
		else $error("write with nonzero pad not aborted");
	// Either supply low blocks the store, so a brown-out cannot tear the register.
	a_supply_block: assert property (!pins_reg.bus_supply_ok || !pins_reg.core_supply_ok // see RQ16
		|=> $stable(nv_reg))
		else $error("register written with supply low");
	// An accepted byte lands in the register on the next cycle.
	a_write_store: assert property (wr_done && wr_ok // see RQ12
		|=> nv_reg == $past(shift_reg[NV_WIDTH-1:0]))
		else $error("accepted byte not stored");
	// During a read, each data bit is driven from the top of the shift register.
	a_read_drive: assert property (state_reg == ST_RDATA // see RQ13
		|=> sda_oe_o == !$past(shift_reg[7]))
		else $error("read bit not driven");
	// Traffic for other addresses never sees the data line pulled.
	a_skip_quiet: assert property (state_reg == ST_SKIP |=> !sda_oe_o) // see RQ18
		else $error("data line driven while ignoring");

	// The register changes only in the cycle after a whole byte has been taken.
	a_store_gated: assert property (!wr_done // see RQ17
		|=> $stable(nv_reg))
		else $error("register changed outside a completed byte");
	// An accepted byte is acknowledged by pulling the line in the ninth bit.
	a_wack_pull: assert property (wr_done && wr_ok // see RQ7
		|=> ##1 sda_oe_o == 1'b1)
		else $error("accepted byte not acknowledged");
	// The address acknowledge is reached only through a matching address.
	a_addr_match: assert property (state_reg == ST_AACK && $past(state_reg) == ST_ADDR // see RQ10
		|-> $past(shift_reg[7:1]) == DEV_ADDR)
		else $error("address acknowledge without own address");
	// After the eighth read bit the line is released for the host's answer.
	a_read_release: assert property (state_reg == ST_RACK // see RQ11
		|=> !sda_oe_o)
		else $error("data line driven after eighth read bit");
	// An idle slave keeps the data line released.
	a_idle_quiet: assert property (state_reg == ST_IDLE |=> !sda_oe_o) // see RQ18
		else $error("data line driven while idle");

endmodule : ncfg_top

`default_nettype wire

// ===== test/ncfg_host_model.sv
// Bus host model: drives the serial clock and data line for one-byte transfers.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module ncfg_host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	////////////////////////////////////////
	// Idle bus: the clock stands high and the data line is released.
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// Waits one quarter of the 400 ns bus clock period.
	task automatic qtr;
		repeat (2) @(posedge clk_i);
	endtask : qtr

	// Sends one bit while the clock is low and samples the line in mid high phase.
	task automatic bit_io(input logic b, output logic s);
		sda_low_o <= !b;
		qtr();
		scl_o <= 1'b1;
		qtr();
		s = sda_i;
		qtr();
		scl_o <= 1'b0;
		qtr();
	endtask : bit_io

	// Start, address with direction, acknowledge bit, one data byte, acknowledge bit, stop.
	task automatic xfer(input logic [7:0] ab, input logic [7:0] db, output logic ack_a, output logic ack_d,
		output logic [7:0] rd);
		logic s;
		sda_low_o <= 1'b1;
		qtr();
		scl_o <= 1'b0;
		qtr();
		for (int i = 7; i >= 0; i--) begin
			bit_io(ab[i], s);
		end
		bit_io(1'b1, s);
		ack_a = !s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(ab[0] | db[i], rd[i]);
		end
		bit_io(1'b1, s);
		ack_d = !s;
		sda_low_o <= 1'b1;
		qtr();
		scl_o <= 1'b1;
		qtr();
		sda_low_o <= 1'b0;
		qtr();
	endtask : xfer

endmodule : ncfg_host_model
`default_nettype wire

// ===== test/ncfg_top_tb_top.sv
// Testbench for the configuration selector: pins driven directly, register reached over the bus.
// Assumes the host model file and resolves the open-drain data line here with a pull-up.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end

module ncfg_top_tb_top;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic force_low_n_i = 1'b1;
	logic write_lock_i = 1'b0;
	logic path_select_i = 1'b0;
	logic bus_supply_ok_i = 1'b1;
	logic core_supply_ok_i = 1'b1;
	logic [3:0] ext_inputs_i = 4'h0;
	logic scl, sda_low, sda_o, sda_oe_o, held_output_o, aa, ad;
	logic [3:0] selector_outputs_o;
	logic [7:0] rd;
	wire sda_line;
	int errors = 0;
	int num_checks = 0;

	////////////////////////////////////////
	// Clock, wired-and data line and the two instances.
	always #25 clk_i = ~clk_i;
	assign sda_line = !(sda_low || (sda_oe_o && !sda_o));
	ncfg_host_model i_ncfg_host_model (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
	ncfg_top i_ncfg_top (.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .force_low_n_i(force_low_n_i), .write_lock_i(write_lock_i),
		.path_select_i(path_select_i), .bus_supply_ok_i(bus_supply_ok_i), .core_supply_ok_i(core_supply_ok_i),
		.ext_inputs_i(ext_inputs_i), .selector_outputs_o(selector_outputs_o), .held_output_o(held_output_o));

	// Lets a pin change pass the synchronisers, then compares both outputs.
	task automatic chk_out(input logic [3:0] sel, input logic held);
		repeat (5) @(negedge clk_i);
		`CHK("selector", sel, selector_outputs_o)
		`CHK("held", held, held_output_o)
	endtask : chk_out

	// Writes one byte to the own address and checks both acknowledges.
	task automatic wr(input logic [7:0] d, input logic ok);
		i_ncfg_host_model.xfer({ncfg_pkg::DEV_ADDR_DEFAULT, 1'b0}, d, aa, ad, rd);
		`CHK("addr ack", 1'b1, aa)
		`CHK("data ack", ok, ad)
	endtask : wr

	// Reads the register back and compares the byte.
	task automatic rdb(input logic [7:0] e);
		i_ncfg_host_model.xfer({ncfg_pkg::DEV_ADDR_DEFAULT, 1'b1}, 8'hff, aa, ad, rd);
		`CHK("read data", e, rd)
	endtask : rdb

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	// Cuts a hang short after far more cycles than the tests need.
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		report_and_stop();
	end

	// Main test sequence.
	initial begin
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk_out(4'h0, 1'b0);
		rdb(8'h00);
		wr(8'h15, 1'b1);
		chk_out(4'h5, 1'b1);
		rdb(8'h15);
		@(posedge clk_i) write_lock_i <= 1'b1;
		wr(8'h0a, 1'b0);
		@(posedge clk_i) write_lock_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_i) bus_supply_ok_i <= (i != 0);
			@(posedge clk_i) core_supply_ok_i <= (i != 1);
			repeat (4) @(posedge clk_i);
			wr(i < 2 ? 8'h0a : 8'h0a | (8'h10 << (i - 1)), 1'b0);
		end
		rdb(8'h15);
		chk_out(4'h5, 1'b1);
		i_ncfg_host_model.xfer({ncfg_pkg::DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, 8'h00, aa, ad, rd);
		`CHK("foreign ack", 1'b0, aa)
		`CHK("foreign data ack", 1'b0, ad)
		rdb(8'h15);
		@(posedge clk_i) ext_inputs_i <= 4'hc;
		@(posedge clk_i) path_select_i <= 1'b1;
		chk_out(4'hc, 1'b1);
		wr(8'h00, 1'b1);
		chk_out(4'hc, 1'b1);
		@(posedge clk_i) ext_inputs_i <= 4'h3;
		chk_out(4'h3, 1'b1);
		@(posedge clk_i) path_select_i <= 1'b0;
		chk_out(4'h0, 1'b0);
		wr(8'h1f, 1'b1);
		chk_out(4'hf, 1'b1);
		@(posedge clk_i) force_low_n_i <= 1'b0;
		chk_out(4'h0, 1'b0);
		@(posedge clk_i) path_select_i <= 1'b1;
		chk_out(4'h3, 1'b0);
		report_and_stop();
	end

endmodule : ncfg_top_tb_top
`default_nettype wire
